// ### hw/rwc_pkg.sv
// Shared constants for the receive stream width and clock crossing adapter.
package rwc_pkg;

    // ==========================================================================
    // Stream and entry layout
    // ==========================================================================
    localparam int NARROW_W = 32;
    localparam int WIDE_W = 64;
    localparam int ENTRY_W = 69;
    localparam int KEEP_LSB = 64;
    localparam int KEEP_MSB = 66;
    localparam int ERR_BIT = 67;
    localparam int EOP_BIT = 68;
    localparam int FIFO_DEPTH = 32;

    // ==========================================================================
    // Cancel thresholds
    // ==========================================================================
    localparam int LEN_W = 14;
    localparam logic [13:0] MAX_FRAME_BYTES = 14'h2336;
    localparam int MIN_FREE_ENTRIES = 8;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic SELECT_RST = 1'b0;
    localparam logic FRESH_RST = 1'b1;

    // Write side state: passing words, or discarding the tail of a cancelled packet.
    typedef enum logic {RWC_WR_PASS, RWC_WR_DROP} rwc_wr_state_e;

endpackage : rwc_pkg

// ### hw/rwc_dual_clock_prefetch_fifo.sv
// Asynchronous first-word-fall-through FIFO with gray-coded pointers and a registered head.
`timescale 1ns/1ps
`default_nettype none

module rwc_dual_clock_prefetch_fifo #(
    parameter int DATA_W = 69,
    parameter int DEPTH = 32
) (
    // Write domain.
    input wire logic wr_clk_i,
    input wire logic wr_rst_i,
    input wire logic wr_en_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    output logic [$clog2(DEPTH):0] wr_free_o,
    // Read domain.
    input wire logic rd_clk_i,
    input wire logic rd_rst_i,
    input wire logic rd_pop_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_empty_o
);
    import rwc_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    logic [DATA_W-1:0] mem [DEPTH];

    // Read pointer in gray code; declared here because the write domain synchronises it.
    logic [AW:0] rgray_reg_x;

    // ==========================================================================
    // Write domain
    // ==========================================================================
    logic [AW:0] wbin_reg, wbin_next, wgray_reg, rgray_s1_reg, rgray_s2_reg;
    logic [AW:0] used;
    logic full;

    // Occupancy is seen late through the synchroniser, so free space is pessimistic, never optimistic.
    always_comb
    begin
        used = wbin_reg - gray2bin(rgray_s2_reg);
        full = (used == DEPTH_CNT);
        wr_free_o = DEPTH_CNT - used;
        wbin_next = wbin_reg + {{AW{1'b0}}, (wr_en_i && !full)};
    end

    always_ff @(posedge wr_clk_i)
    begin
        if (wr_en_i && !full)
        begin
            mem[wbin_reg[AW-1:0]] <= wr_data_i;
        end
        if (wr_rst_i)
        begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rgray_s1_reg <= '0;
            rgray_s2_reg <= '0;
        end
        else
        begin
            wbin_reg <= wbin_next;
            wgray_reg <= bin2gray(wbin_next);
            rgray_s1_reg <= rgray_reg_x;
            rgray_s2_reg <= rgray_s1_reg;
        end
    end

    // ==========================================================================
    // Read domain
    // ==========================================================================
    logic [AW:0] rbin_reg, rbin_next, wgray_s1_reg, wgray_s2_reg;
    logic [DATA_W-1:0] head_reg, head_next;
    logic head_vld_reg, head_vld_next, load;

    // The head register keeps the first word on show; popping it refills from memory.
    always_comb
    begin
        load = (rgray_reg_x != wgray_s2_reg) && (!head_vld_reg || rd_pop_i);
        rbin_next = rbin_reg + {{AW{1'b0}}, load};
        head_next = load ? mem[rbin_reg[AW-1:0]] : head_reg;
        head_vld_next = load ? 1'b1 : (rd_pop_i ? 1'b0 : head_vld_reg);
    end

    always_ff @(posedge rd_clk_i)
    begin
        if (rd_rst_i)
        begin
            rbin_reg <= '0;
            rgray_reg_x <= '0;
            wgray_s1_reg <= '0;
            wgray_s2_reg <= '0;
            head_reg <= '0;
            head_vld_reg <= 1'b0;
        end
        else
        begin
            rbin_reg <= rbin_next;
            rgray_reg_x <= bin2gray(rbin_next);
            wgray_s1_reg <= wgray_reg;
            wgray_s2_reg <= wgray_s1_reg;
            head_reg <= head_next;
            head_vld_reg <= head_vld_next;
        end
    end

    assign rd_data_o = head_reg;
    assign rd_empty_o = !head_vld_reg;

endmodule : rwc_dual_clock_prefetch_fifo

`default_nettype wire

// ### hw/rwc_rx_width_adapter.sv
// Receive adapter: pairs 32-bit MAC words into 64-bit entries and crosses them to the user clock.
//
// Contract
// R1 - Cancel the packet being written once its length exceeds 9014 bytes.
// R2 - Cancel the packet being written when buffer free space falls below 8 entries.
// R3 - A cancel writes one entry with error, end-of-packet and write strobe set.
// R4 - Entries are 69 bits: 64 data, 3 keep code, error, end-of-packet.
// R5 - Crossing buffer is an asynchronous first-word-fall-through FIFO, MAC to user clock.
// R6 - Half selector resets to 0, toggles on each valid input word; the code clears it on a last word or a cancel and holds it while dropping.
// R7 - Compress 4-bit byte enable to two keep bits: 0001,0011,0111,1111 to 0..3.
// R8 - Keep code bit 2 is taken from the half selector being 1.
// R9 - Input word goes to lower half at selector 0, upper half at 1.
// R10 - Write strobe pulses with the upper half load, writing all fields together.
// R11 - With input valid low, selector, assembled data and keep code hold.
// R12 - Final word at selector 1 gives a last entry with keep bit 2 set.
// R13 - Final word at selector 0 gives a lower-only last entry; selector stays 0.
// R14 - Pop at once when FIFO not empty and fresh-fetch flag is set.
// R15 - With a word latched, clear fresh-fetch; pop only when user accepts.
// R16 - After a pop, raise output valid, load data bits 63:0 and last bit 68.
// R17 - Expand keep code bits 66:64 to byte enable, 000 to 01h up to FFh.
// R18 - On accepting the latched word with FIFO empty, set fresh-fetch, drop valid.
// R19 - Buffer holds 32 entries; error flag sits in entry bit 67.
// R20 - User side transfers a word only when valid and ready are both high.
`timescale 1ns/1ps
`default_nettype none

module rwc_rx_width_adapter #(
    parameter int FIFO_DEPTH = rwc_pkg::FIFO_DEPTH
) (
    // MAC side clock and reset.
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // User side clock.
    input wire logic user_side_clk_i,
    // Narrow receive stream from the MAC.
    input wire logic narrow_in_vld_i,
    input wire logic narrow_in_eop_i,
    input wire logic [3:0] narrow_in_bytes_i,
    input wire logic [rwc_pkg::NARROW_W-1:0] narrow_in_word_i,
    // Wide stream to the user.
    output logic out_vld_o,
    input wire logic out_rdy_i,
    output logic [rwc_pkg::WIDE_W-1:0] out_word_o,
    output logic out_eop_o,
    output logic [7:0] out_bytes_o
);
    import rwc_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);

    // Two low keep bits from a contiguous 4-bit byte enable.
    function automatic logic [1:0] compress_bytes(input logic [3:0] be);
        logic [1:0] c;
        c = 2'h0;
        if (be[3])
        begin
            c = 2'h3;
        end
        else if (be[2])
        begin
            c = 2'h2;
        end
        else if (be[1])
        begin
            c = 2'h1;
        end
        return c;
    endfunction : compress_bytes

    // Number of valid bytes, 1 to 4, in one narrow word.
    function automatic logic [2:0] count_bytes(input logic [3:0] be);
        return {1'b0, compress_bytes(be)} + 3'h1;
    endfunction : count_bytes

    // Byte enable for the wide word from the keep code.
    function automatic logic [7:0] expand_keep(input logic [2:0] code);
        return 8'hFF >> (3'h7 - code);
    endfunction : expand_keep

    // ==========================================================================
    // Write side: pairing and cancel detection (MAC clock)
    // ==========================================================================
    rwc_wr_state_e wr_state_reg, wr_state_next;
    logic upper_half_select_reg, upper_half_select_next;
    logic [WIDE_W-1:0] wide_word_bits_reg, wide_word_bits_next;
    logic [2:0] wide_keep_code_reg, wide_keep_code_next;
    logic wide_err_flag_reg, wide_err_flag_next;
    logic wide_eop_flag_reg, wide_eop_flag_next;
    logic wide_word_write_reg, wide_word_write_next;
    logic [LEN_W-1:0] frame_len_reg, frame_len_next, len_sum;
    logic [AW:0] wr_free;
    logic cancel_now;

    // Cancelling on arrival keeps the buffer from ever overflowing, since the MAC cannot be stalled.
    always_comb
    begin
        len_sum = frame_len_reg + LEN_W'(count_bytes(narrow_in_bytes_i));
        cancel_now = narrow_in_vld_i && (wr_state_reg == RWC_WR_PASS) &&
            ((len_sum > MAX_FRAME_BYTES) || (wr_free < (AW+1)'(MIN_FREE_ENTRIES))); // see R1 see R2
        wr_state_next = wr_state_reg;
        upper_half_select_next = upper_half_select_reg;
        wide_word_bits_next = wide_word_bits_reg;
        wide_keep_code_next = wide_keep_code_reg;
        wide_err_flag_next = wide_err_flag_reg;
        wide_eop_flag_next = wide_eop_flag_reg;
        wide_word_write_next = 1'b0;
        frame_len_next = frame_len_reg;
        if (narrow_in_vld_i) // see R11
        begin
            case (wr_state_reg)
                RWC_WR_PASS:
                begin
                    if (cancel_now)
                    begin
                        // Close the packet as errored; drop the rest unless this was its last word.
                        wide_err_flag_next = 1'b1; // see R3
                        wide_eop_flag_next = 1'b1;
                        wide_word_write_next = 1'b1;
                        upper_half_select_next = SELECT_RST;
                        frame_len_next = '0;
                        wr_state_next = narrow_in_eop_i ? RWC_WR_PASS : RWC_WR_DROP;
                    end
                    else
                    begin
                        if (upper_half_select_reg) // see R9
                        begin
                            wide_word_bits_next[WIDE_W-1:NARROW_W] = narrow_in_word_i;
                        end
                        else
                        begin
                            wide_word_bits_next[NARROW_W-1:0] = narrow_in_word_i;
                        end
                        wide_keep_code_next = {upper_half_select_reg, compress_bytes(narrow_in_bytes_i)}; // see R7 see R8
                        wide_err_flag_next = 1'b0;
                        wide_eop_flag_next = narrow_in_eop_i; // see R12 see R13
                        wide_word_write_next = upper_half_select_reg || narrow_in_eop_i; // see R10
                        upper_half_select_next = narrow_in_eop_i ? 1'b0 : !upper_half_select_reg; // see R6 see R13
                        frame_len_next = narrow_in_eop_i ? '0 : len_sum;
                    end
                end
                RWC_WR_DROP:
                begin
                    if (narrow_in_eop_i)
                    begin
                        wr_state_next = RWC_WR_PASS;
                    end
                end
                default:
                begin
                    wr_state_next = RWC_WR_PASS;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            wr_state_reg <= RWC_WR_PASS;
            upper_half_select_reg <= SELECT_RST; // see R6
            wide_word_bits_reg <= '0;
            wide_keep_code_reg <= '0;
            wide_err_flag_reg <= 1'b0;
            wide_eop_flag_reg <= 1'b0;
            wide_word_write_reg <= 1'b0;
            frame_len_reg <= '0;
        end
        else
        begin
            wr_state_reg <= wr_state_next;
            upper_half_select_reg <= upper_half_select_next;
            wide_word_bits_reg <= wide_word_bits_next;
            wide_keep_code_reg <= wide_keep_code_next;
            wide_err_flag_reg <= wide_err_flag_next;
            wide_eop_flag_reg <= wide_eop_flag_next;
            wide_word_write_reg <= wide_word_write_next;
            frame_len_reg <= frame_len_next;
        end
    end

    // ==========================================================================
    // Crossing buffer
    // ==========================================================================
    logic user_rst_s1_reg, user_rst_reg;
    logic [ENTRY_W-1:0] cross_fifo_head;
    logic cross_fifo_empty, cross_fifo_pop;

    // Reset level brought into the user clock through two flops.
    always_ff @(posedge user_side_clk_i)
    begin
        user_rst_s1_reg <= reset_i;
        user_rst_reg <= user_rst_s1_reg;
    end

    // Entry packs last, error, keep code and data from top to bottom.
    rwc_dual_clock_prefetch_fifo #(
        .DATA_W(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo ( // see R5 see R19
        .wr_clk_i(ref_clk_i),
        .wr_rst_i(reset_i),
        .wr_en_i(wide_word_write_reg),
        .wr_data_i({wide_eop_flag_reg, wide_err_flag_reg, wide_keep_code_reg, wide_word_bits_reg}), // see R4
        .wr_free_o(wr_free),
        .rd_clk_i(user_side_clk_i),
        .rd_rst_i(user_rst_reg),
        .rd_pop_i(cross_fifo_pop),
        .rd_data_o(cross_fifo_head),
        .rd_empty_o(cross_fifo_empty)
    );

    // ==========================================================================
    // Read controller (user clock)
    // ==========================================================================
    logic fresh_fetch_flag_reg, fresh_fetch_flag_next;
    logic out_vld_reg, out_vld_next, out_eop_reg, out_eop_next;
    logic [WIDE_W-1:0] out_word_reg, out_word_next;
    logic [7:0] out_bytes_reg, out_bytes_next;
    logic accept;

    // The error bit stays internal; an errored packet shows only as a short packet to the user.
    always_comb
    begin
        accept = out_vld_reg && out_rdy_i; // see R20
        cross_fifo_pop = !cross_fifo_empty && (fresh_fetch_flag_reg || accept); // see R14 see R15
        fresh_fetch_flag_next = fresh_fetch_flag_reg;
        out_vld_next = out_vld_reg;
        out_word_next = out_word_reg;
        out_eop_next = out_eop_reg;
        out_bytes_next = out_bytes_reg;
        if (cross_fifo_pop)
        begin
            fresh_fetch_flag_next = 1'b0; // see R15
            out_vld_next = 1'b1; // see R16
            out_word_next = cross_fifo_head[WIDE_W-1:0];
            out_eop_next = cross_fifo_head[EOP_BIT];
            out_bytes_next = expand_keep(cross_fifo_head[KEEP_MSB:KEEP_LSB]); // see R17
        end
        else if (accept)
        begin
            fresh_fetch_flag_next = 1'b1; // see R18
            out_vld_next = 1'b0;
        end
    end

    always_ff @(posedge user_side_clk_i)
    begin
        if (user_rst_reg)
        begin
            fresh_fetch_flag_reg <= FRESH_RST;
            out_vld_reg <= 1'b0;
            out_word_reg <= '0;
            out_eop_reg <= 1'b0;
            out_bytes_reg <= '0;
        end
        else
        begin
            fresh_fetch_flag_reg <= fresh_fetch_flag_next;
            out_vld_reg <= out_vld_next;
            out_word_reg <= out_word_next;
            out_eop_reg <= out_eop_next;
            out_bytes_reg <= out_bytes_next;
        end
    end

    assign out_vld_o = out_vld_reg;
    assign out_word_o = out_word_reg;
    assign out_eop_o = out_eop_reg;
    assign out_bytes_o = out_bytes_reg;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    sequence s_upper_word;
        narrow_in_vld_i && upper_half_select_reg && (wr_state_reg == RWC_WR_PASS) && !cancel_now;
    endsequence

    sequence s_lower_last;
        narrow_in_vld_i && narrow_in_eop_i && !upper_half_select_reg && !cancel_now &&
            (wr_state_reg == RWC_WR_PASS);
    endsequence

    sequence s_drain_last;
        out_vld_reg && out_rdy_i && cross_fifo_empty;
    endsequence

    AST_SEL_CLEARS: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R6
        narrow_in_vld_i && upper_half_select_reg |=> !upper_half_select_reg)
        else $error("Half selector did not return to lower half.");

    AST_HOLD_IDLE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R11
        !narrow_in_vld_i |=> $stable(upper_half_select_reg) && $stable(wide_word_bits_reg) &&
            $stable(wide_keep_code_reg))
        else $error("Assembly state changed while input was idle.");

    AST_WRITE_UPPER: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R10
        s_upper_word |=> wide_word_write_reg && (wide_word_bits_reg[WIDE_W-1:NARROW_W] == $past(narrow_in_word_i)))
        else $error("Upper half load did not write the buffer.");

    AST_KEEP_HI: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R8
        s_upper_word ##1 !wide_err_flag_reg |-> wide_keep_code_reg[2] && wide_word_write_reg)
        else $error("Keep bit 2 missing on an upper half entry.");

    AST_CANCEL_ENTRY: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R3
        cancel_now |=> wide_word_write_reg && wide_err_flag_reg && wide_eop_flag_reg)
        else $error("Cancel did not close the packet with an error entry.");

    AST_LOW_SPACE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R2
        narrow_in_vld_i && (wr_state_reg == RWC_WR_PASS) && (wr_free < (AW+1)'(MIN_FREE_ENTRIES)) |=>
            wide_word_write_reg && wide_err_flag_reg && wide_eop_flag_reg)
        else $error("Low buffer space did not cancel the packet.");

    AST_LOWER_LAST: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see R13
        s_lower_last |=> wide_word_write_reg && wide_eop_flag_reg && !wide_keep_code_reg[2] && !upper_half_select_reg)
        else $error("Lower-only last entry written wrongly.");

    AST_POP_FRESH: assert property (@(posedge user_side_clk_i) disable iff (user_rst_reg) // see R14
        !cross_fifo_empty && fresh_fetch_flag_reg |-> cross_fifo_pop)
        else $error("No immediate pop with fresh-fetch set.");

    AST_POP_STALL: assert property (@(posedge user_side_clk_i) disable iff (user_rst_reg) // see R15
        out_vld_reg && !out_rdy_i |-> !cross_fifo_pop ##1 (out_word_reg == $past(out_word_reg)))
        else $error("Pop while the latched word was not accepted.");

    AST_POP_LOAD: assert property (@(posedge user_side_clk_i) disable iff (user_rst_reg) // see R16
        cross_fifo_pop |=> out_vld_reg && (out_word_reg == $past(cross_fifo_head[WIDE_W-1:0])) &&
            (out_eop_reg == $past(cross_fifo_head[EOP_BIT])))
        else $error("Output not loaded from the popped entry.");

    AST_DRAIN: assert property (@(posedge user_side_clk_i) disable iff (user_rst_reg) // see R18
        s_drain_last |=> fresh_fetch_flag_reg && !out_vld_reg)
        else $error("Drain did not set fresh-fetch and drop valid.");

endmodule : rwc_rx_width_adapter

`default_nettype wire

// ### tb/rwc_user_sink.sv
// Behavioural user-side sink that accepts wide words and reports each transfer.
`timescale 1ns/1ps
`default_nettype none

module rwc_user_sink (
    // Clock and stall control.
    input wire logic clk_i,
    input wire logic stall_i,
    // Wide stream from the adapter.
    input wire logic vld_i,
    output logic rdy_o,
    input wire logic [63:0] word_i,
    input wire logic eop_i,
    input wire logic [7:0] bytes_i,
    // Report of each completed transfer.
    output logic got_o,
    output logic [63:0] got_word_o,
    output logic got_eop_o,
    output logic [7:0] got_bytes_o
);
    // ==========================================================================
    // Handshake
    // ==========================================================================
    // Ready moves only after an edge, so a word is never half taken.
    initial rdy_o = 1'b0;
    initial got_o = 1'b0;
    always @(posedge clk_i)
    begin
        got_o <= vld_i && rdy_o;
        got_word_o <= word_i;
        got_eop_o <= eop_i;
        got_bytes_o <= bytes_i;
        rdy_o <= !stall_i;
    end
endmodule : rwc_user_sink
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the receive width and clock crossing adapter.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rwc_pkg::*;
    localparam int TB_DEPTH = 16;
    logic ref_clk_i = 0, usr_clk = 0, reset_i = 1, vld = 0, eop = 0, hold = 1, stall = 1;
    logic [31:0] word = 0, seed = 20, st = 20;
    logic [3:0] bytes = 4'h1;
    logic rdy, ovld, oeop, got, geop, loose = 0, last_eop;
    logic [63:0] oword, gword, ew[$];
    logic [7:0] obytes, gbytes, eb[$];
    logic ee[$], ed[$];
    int miscompares = 0, tests_run = 0, loose_n = 0;

    // ==========================================================================
    // Clocks, design and sink
    // ==========================================================================
    // The user clock is unrelated to the MAC clock so crossings really happen.
    initial forever #5 ref_clk_i = ~ref_clk_i;
    initial forever #3.5 usr_clk = ~usr_clk;
    rwc_rx_width_adapter #(.FIFO_DEPTH(TB_DEPTH)) rwc_rx_width_adapter_inst (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .user_side_clk_i(usr_clk), .narrow_in_vld_i(vld), .narrow_in_eop_i(eop),
        .narrow_in_bytes_i(bytes), .narrow_in_word_i(word), .out_vld_o(ovld), .out_rdy_i(rdy),
        .out_word_o(oword), .out_eop_o(oeop), .out_bytes_o(obytes));
    rwc_user_sink rwc_user_sink_inst (.clk_i(usr_clk), .stall_i(stall), .vld_i(ovld), .rdy_o(rdy),
        .word_i(oword), .eop_i(oeop), .bytes_i(obytes), .got_o(got), .got_word_o(gword),
        .got_eop_o(geop), .got_bytes_o(gbytes));

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [63:0] bitmask(input logic [7:0] b);
        logic [63:0] m;
        for (int i = 0; i < 8; i++) m[i*8 +: 8] = {8{b[i]}};
        return m;
    endfunction : bitmask

    task automatic check(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic push(input logic [63:0] w, input logic [2:0] c, input logic e, input logic d);
        ew.push_back(w);
        eb.push_back(8'hFF >> (3'd7 - c));
        ee.push_back(e);
        ed.push_back(d);
    endtask : push

    // Drives one packet; the expectation follows pairing, length cancel and drop.
    task automatic send(input int n, input logic [1:0] lc, input bit trk, input bit gaps);
        logic sel, last, drop;
        logic [31:0] lo;
        logic [1:0] c;
        int len;
        sel = 0; drop = 0; len = 0; lo = 0;
        for (int i = 0; i < n; i++)
        begin
            last = (i == n - 1);
            c = last ? lc : 2'd3;
            seed = xs(seed);
            @(posedge ref_clk_i);
            #1;
            if (gaps && seed[7:6] == 2'd0)
            begin
                vld = 0;
                @(posedge ref_clk_i);
                #1;
            end
            vld = 1; eop = last; bytes = 4'hF >> (2'd3 - c); word = seed;
            if (trk && !drop)
            begin
                if (len + c + 1 > int'(MAX_FRAME_BYTES))
                begin
                    // The error entry keeps the keep code of the last stored word, a full upper or lower half.
                    push(64'h0, {~sel, 2'd3}, 1'b1, 1'b0);
                    drop = 1;
                end
                else if (sel)
                begin
                    push({seed, lo}, {1'b1, c}, last, 1'b1);
                    sel = 0;
                end
                else if (last) push({32'h0, seed}, {1'b0, c}, 1'b1, 1'b1);
                else
                begin
                    lo = seed;
                    sel = 1;
                end
                len = len + c + 1;
            end
        end
        @(posedge ref_clk_i);
        #1;
        vld = 0; eop = 0;
    endtask : send

    task automatic drain;
        for (int k = 0; k < 3000 && ew.size() > 0; k++) @(posedge ref_clk_i);
        check(64'(ew.size()), 64'h0);
    endtask : drain

    task automatic conclude;
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // ==========================================================================
    // Sink stalls and output monitor
    // ==========================================================================
    // Stalls use their own generator so the stimulus order never depends on them.
    always @(posedge ref_clk_i)
    begin
        #1;
        st = xs(st);
        stall = hold | (st[1:0] == 2'd0);
    end

    always @(negedge usr_clk)
    begin
        if (got && loose)
        begin
            loose_n++;
            last_eop = geop;
        end
        else if (got && ew.size() == 0) check(64'h1, 64'h0);
        else if (got)
        begin
            check(gbytes, eb[0]);
            check(geop, ee[0]);
            check(gword & bitmask(eb[0]) & {64{ed[0]}}, ew[0] & bitmask(eb[0]) & {64{ed[0]}});
            void'(ew.pop_front()); void'(eb.pop_front()); void'(ee.pop_front()); void'(ed.pop_front());
        end
    end

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial
    begin
        #500000;
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        #1;
        reset_i = 0;
        repeat (4) @(posedge ref_clk_i);
        hold = 0;
        for (int c = 0; c < 4; c++)
        begin
            send(1, 2'(c), 1, 0);
            send(2, 2'(c), 1, 0);
            send(3, 2'(c), 1, 1);
        end
        drain();
        for (int p = 0; p < 40; p++)
        begin
            seed = xs(seed);
            send(1 + int'(seed % 40), seed[9:8], 1, 1);
        end
        drain();
        send(2254, 2'd1, 1, 0);
        send(2254, 2'd2, 1, 1);
        send(2300, 2'd3, 1, 1);
        send(5, 2'd3, 1, 1);
        drain();
        hold = 1;
        loose = 1;
        send(40, 2'd3, 0, 0);
        repeat (100) @(posedge ref_clk_i);
        hold = 0;
        repeat (300) @(posedge ref_clk_i);
        loose = 0;
        // Memory stops at free space plus one; the FIFO head and the output register hold two more, plus the error entry.
        check(64'(loose_n <= TB_DEPTH - MIN_FREE_ENTRIES + 4), 64'h1);
        check(64'(loose_n >= 2), 64'h1);
        check(64'(last_eop), 64'h1);
        send(3, 2'd0, 1, 1);
        drain();
        conclude();
    end
endmodule : testbench
`default_nettype wire
